// File: fsr_commit_check.sv
`default_nettype none
module fsr_commit_check
  import fsr_pkg::*;
(
  fsr_commit_if.checker_side chk
);
  // Resolution must be one of the listed divisions or a multiple of 4 inside its range; the frame code stays inside its band.
  function automatic logic res_legal(input logic [15:0] r);
    unique case (r)
      16'h0004, 16'h0008, 16'h000A, 16'h0010, 16'h0014, 16'h0019, 16'h0020, 16'h0028,
      16'h0032, 16'h0040, 16'h0050, 16'h0064, 16'h0080, 16'h00C8, 16'h00FA: res_legal = 1'b1;
      default: res_legal = (r >= STEP_RES_MIN) && (r <= STEP_RES_MAX) && (r[1:0] == 2'b00);
    endcase
  endfunction
  always_comb begin
    chk.ok = res_legal(chk.res) && (chk.frame >= FRAME_SEL_MIN) && (chk.frame <= FRAME_SEL_MAX)
             && ((chk.cfg & ~DRV_CFG_MASK) == 16'h0000) && chk.cfg[14];
  end
endmodule
`default_nettype wire

// File: fsr_commit_if.sv
`default_nettype none
interface fsr_commit_if;
  logic [15:0] cfg;
  logic [15:0] res;
  logic [15:0] frame;
  logic ok;
  modport checker_side(input cfg, input res, input frame, output ok);
  modport bank_side(output cfg, output res, output frame, input ok);
endinterface
`default_nettype wire

// File: fsr_host_model.sv
`default_nettype none
module fsr_host_model
  import fsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [15:0] rd_data,
  output logic wr_en,
  output logic rd_en,
  output logic [3:0] addr,
  output logic [15:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // An idle bus shows the inverse of the last word, so stale data never looks like a fresh request.
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'hF;
    wr_data = 16'hFFFF;
  end
  task automatic write_word(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] x;
    x = (a == ADDR_RSVD_A || a == ADDR_RSVD_B) ? 16'h0000 : d;
    x = (a == ADDR_HOST_CTRL) ? (x & HOST_CTRL_MASK) : x;
    @(negedge sys_clk);
    addr <= a;
    wr_data <= x;
    wr_en <= 1'b1;
    @(negedge sys_clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~x;
  endtask
  task automatic read_word(input logic [3:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(negedge sys_clk);
    rd_en <= 1'b0;
    addr <= ~a;
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// File: fsr_pkg.sv
`default_nettype none
package fsr_pkg;
  localparam logic [3:0] ADDR_RSVD_A = 4'h0;
  localparam logic [3:0] ADDR_HOST_CTRL = 4'h2;
  localparam logic [3:0] ADDR_RUN_RATE = 4'h4;
  localparam logic [3:0] ADDR_HOLD_RATE = 4'h6;
  localparam logic [3:0] ADDR_RSVD_B = 4'h8;
  localparam logic [3:0] ADDR_DRV_CFG = 4'hA;
  localparam logic [3:0] ADDR_STEP_RES = 4'hC;
  localparam logic [3:0] ADDR_FRAME_SEL = 4'hE;
  localparam int BIT_ALARM_LAMP_SUPPRESS = 15;
  localparam int BIT_POWER_LAMP_SUPPRESS = 14;
  localparam int BIT_COMMAND_FILTER_ON = 9;
  localparam int BIT_SMOOTH_DRIVE_ON = 8;
  localparam int BIT_COMM_ERROR_CLEAR = 3;
  localparam int BIT_ALARM_CLEAR_REQUEST = 2;
  localparam int BIT_EXCITE = 1;
  localparam logic [15:0] HOST_CTRL_MASK = 16'hC30E;
  localparam logic [15:0] HOST_CTRL_RESET = 16'h0100;
  localparam logic [15:0] RUN_RATE_MIN = 16'h0001;
  localparam logic [15:0] RUN_RATE_MAX = 16'h03E8;
  localparam logic [15:0] RUN_RATE_RESET = 16'h03E8;
  localparam logic [15:0] HOLD_RATE_MIN = 16'h0001;
  localparam logic [15:0] HOLD_RATE_MAX = 16'h01F4;
  localparam logic [15:0] HOLD_RATE_RESET = 16'h01F4;
  localparam logic [15:0] RATE_SCALE = 16'h03E8;
  localparam logic [15:0] DRV_CFG_MASK = 16'h7E48;
  localparam logic [15:0] DRV_CFG_FIXED = 16'h4000;
  localparam logic [15:0] DRV_CFG_RESET = 16'h7800;
  localparam logic [15:0] STEP_RES_MIN = 16'h0004;
  localparam logic [15:0] STEP_RES_MAX = 16'h09C4;
  localparam logic [15:0] STEP_RES_RESET = 16'h000A;
  localparam logic [15:0] FRAME_SEL_MIN = 16'hFA05;
  localparam logic [15:0] FRAME_SEL_MAX = 16'hFF00;
  localparam logic [15:0] FRAME_SEL_RESET = 16'hFF00;
  localparam logic [15:0] RSVD_READ_VALUE = 16'h0000;
  localparam logic [15:0] RATED_MA_BASE = 16'h015E;
  localparam logic [15:0] RATED_MA_STEP = 16'h0032;
  typedef enum logic {ST_SETTING, ST_OPERATION} drv_state_e;
endpackage
`default_nettype wire

// File: stepper_function_setting_regs.sv
`default_nettype none
module stepper_function_setting_regs
  import fsr_pkg::*;
#(
  parameter int ERR_CNT_W = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [3:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic commit_settings_command,
  input wire logic comm_error_event,
  output logic [15:0] rd_data,
  output logic setting_state,
  output logic alarm_lamp_suppress,
  output logic power_lamp_suppress,
  output logic command_filter_on,
  output logic smooth_drive_on,
  output logic excite_on,
  output logic comm_error_flag,
  output logic [ERR_CNT_W-1:0] comm_error_count,
  output logic comm_error_clear_pulse,
  output logic alarm_clear_pulse,
  output logic cmd_disable_error,
  output logic cmd_disable_alarm,
  output logic [15:0] running_current_rate,
  output logic [15:0] holding_current_rate,
  output logic [15:0] active_driver_config,
  output logic [15:0] active_step_resolution,
  output logic [15:0] active_frame_size,
  output logic [15:0] rated_current_ma,
  output logic [15:0] running_current_ma
);
  typedef struct packed {
    drv_state_e st;
    logic [15:0] host_ctrl;
    logic [15:0] run_rate;
    logic [15:0] hold_rate;
    logic [15:0] cfg_pend;
    logic [15:0] res_pend;
    logic [15:0] frame_pend;
    logic [15:0] cfg_act;
    logic [15:0] res_act;
    logic [15:0] frame_act;
    logic err_flag;
    logic [ERR_CNT_W-1:0] err_cnt;
    logic clr_pulse;
    logic alm_pulse;
    logic cmd_err;
    logic [15:0] rd_data;
    logic [15:0] rated_ma;
    logic [15:0] run_ma;
  } state_s;

  state_s state_reg, state_next;
  fsr_commit_if cif ();
  fsr_commit_check u_check (.chk(cif.checker_side));

  assign cif.cfg = state_reg.cfg_pend;
  assign cif.res = state_reg.res_pend;
  assign cif.frame = state_reg.frame_pend;

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // Rated current grows in fixed steps from the largest frame code downward.
  function automatic logic [15:0] rated_of(input logic [15:0] frame);
    logic [15:0] idx;
    logic [31:0] prod;
    idx = FRAME_SEL_MAX - frame;
    prod = 32'(idx) * 32'(RATED_MA_STEP);
    rated_of = RATED_MA_BASE + prod[15:0];
  endfunction

  logic wr_host, wr_run, wr_hold, wr_defer, bad_imm;
  logic [31:0] run_prod;
  always_comb begin
    wr_host = wr_en && (addr == ADDR_HOST_CTRL);
    wr_run = wr_en && (addr == ADDR_RUN_RATE);
    wr_hold = wr_en && (addr == ADDR_HOLD_RATE);
    wr_defer = wr_en && (state_reg.st == ST_SETTING);
    bad_imm = (wr_run && !in_range(wr_data, RUN_RATE_MIN, RUN_RATE_MAX)) ||
              (wr_hold && !in_range(wr_data, HOLD_RATE_MIN, HOLD_RATE_MAX));
    run_prod = 32'(state_reg.rated_ma) * 32'(state_reg.run_rate) / 32'(RATE_SCALE);
  end

  always_comb begin
    state_next = state_reg;
    state_next.clr_pulse = 1'b0;
    state_next.alm_pulse = 1'b0;
    if (wr_host) begin
      state_next.host_ctrl = wr_data & HOST_CTRL_MASK;
      state_next.clr_pulse = wr_data[BIT_COMM_ERROR_CLEAR] && !state_reg.host_ctrl[BIT_COMM_ERROR_CLEAR];
      state_next.alm_pulse = wr_data[BIT_ALARM_CLEAR_REQUEST] && !state_reg.host_ctrl[BIT_ALARM_CLEAR_REQUEST];
    end
    if (wr_run && !bad_imm) begin
      state_next.run_rate = wr_data;
    end
    if (wr_hold && !bad_imm) begin
      state_next.hold_rate = wr_data;
    end
    if (wr_defer) begin
      unique case (addr)
        ADDR_DRV_CFG: state_next.cfg_pend = wr_data;
        ADDR_STEP_RES: state_next.res_pend = wr_data;
        ADDR_FRAME_SEL: state_next.frame_pend = wr_data;
        default: ;
      endcase
    end
    // Alarm reset clears the command error; commit is taken in setting state only.
    if (state_next.alm_pulse) begin
      state_next.cmd_err = 1'b0;
    end
    if (commit_settings_command && state_reg.st == ST_SETTING) begin
      if (cif.ok) begin
        state_next.st = ST_OPERATION;
        state_next.cfg_act = state_reg.cfg_pend;
        state_next.res_act = state_reg.res_pend;
        state_next.frame_act = state_reg.frame_pend;
      end else begin
        state_next.cmd_err = 1'b1;
        state_next.cfg_pend = state_reg.cfg_act;
        state_next.res_pend = state_reg.res_act;
        state_next.frame_pend = state_reg.frame_act;
      end
    end
    // A new error wins over a clear in the same cycle.
    if (state_next.clr_pulse) begin
      state_next.err_flag = 1'b0;
      state_next.err_cnt = '0;
    end
    // The count saturates, so a burst of link errors cannot wrap it back to a clean zero.
    if (bad_imm || comm_error_event) begin
      state_next.err_flag = 1'b1;
      if (state_next.err_cnt != '1) begin
        state_next.err_cnt = state_next.err_cnt + 1'b1;
      end
    end
    // Reserved slots and reserved host control bits read as zero.
    state_next.rd_data = RSVD_READ_VALUE;
    if (rd_en) begin
      unique case (addr)
        ADDR_HOST_CTRL: state_next.rd_data = state_reg.host_ctrl;
        ADDR_RUN_RATE: state_next.rd_data = state_reg.run_rate;
        ADDR_HOLD_RATE: state_next.rd_data = state_reg.hold_rate;
        ADDR_DRV_CFG: state_next.rd_data = state_reg.cfg_pend;
        ADDR_STEP_RES: state_next.rd_data = state_reg.res_pend;
        ADDR_FRAME_SEL: state_next.rd_data = state_reg.frame_pend;
        default: ;
      endcase
    end
    state_next.rated_ma = rated_of(state_reg.frame_act);
    state_next.run_ma = run_prod[15:0];
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '{st: ST_SETTING, host_ctrl: HOST_CTRL_RESET, run_rate: RUN_RATE_RESET,
                     hold_rate: HOLD_RATE_RESET, cfg_pend: DRV_CFG_RESET, res_pend: STEP_RES_RESET,
                     frame_pend: FRAME_SEL_RESET, cfg_act: DRV_CFG_RESET, res_act: STEP_RES_RESET,
                     frame_act: FRAME_SEL_RESET, err_flag: 1'b0, err_cnt: '0, clr_pulse: 1'b0,
                     alm_pulse: 1'b0, cmd_err: 1'b0, rd_data: 16'h0000, rated_ma: RATED_MA_BASE,
                     run_ma: RATED_MA_BASE};
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data = state_reg.rd_data;
  assign setting_state = (state_reg.st == ST_SETTING);
  assign alarm_lamp_suppress = state_reg.host_ctrl[BIT_ALARM_LAMP_SUPPRESS];
  assign power_lamp_suppress = state_reg.host_ctrl[BIT_POWER_LAMP_SUPPRESS];
  assign command_filter_on = state_reg.host_ctrl[BIT_COMMAND_FILTER_ON];
  assign smooth_drive_on = state_reg.host_ctrl[BIT_SMOOTH_DRIVE_ON];
  assign excite_on = state_reg.host_ctrl[BIT_EXCITE];
  assign comm_error_flag = state_reg.err_flag;
  assign comm_error_count = state_reg.err_cnt;
  assign comm_error_clear_pulse = state_reg.clr_pulse;
  assign alarm_clear_pulse = state_reg.alm_pulse;
  assign cmd_disable_error = state_reg.cmd_err;
  assign cmd_disable_alarm = state_reg.cmd_err;
  assign running_current_rate = state_reg.run_rate;
  assign holding_current_rate = state_reg.hold_rate;
  assign active_driver_config = state_reg.cfg_act;
  assign active_step_resolution = state_reg.res_act;
  assign active_frame_size = state_reg.frame_act;
  assign rated_current_ma = state_reg.rated_ma;
  assign running_current_ma = state_reg.run_ma;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_run_rate_range: assert property (running_current_rate >= RUN_RATE_MIN && running_current_rate <= RUN_RATE_MAX)
    else $error("running rate left its range");
  a_hold_rate_range: assert property (holding_current_rate >= HOLD_RATE_MIN && holding_current_rate <= HOLD_RATE_MAX)
    else $error("holding rate left its range");
  a_bad_imm_keeps: assert property (bad_imm |=> $stable(running_current_rate) && $stable(holding_current_rate) && comm_error_flag)
    else $error("bad immediate write changed a rate or missed the error");
  a_good_run_applies: assert property (wr_run && !bad_imm |=> running_current_rate == $past(wr_data))
    else $error("good running rate write did not apply");
  a_active_frozen_op: assert property (!setting_state && !$past(setting_state) |-> $stable(active_step_resolution))
    else $error("active resolution changed during operation");
  a_commit_bad_stays: assert property (commit_settings_command && setting_state && !cif.ok |=> setting_state && cmd_disable_error)
    else $error("bad commit left setting state or raised no error");
  a_clear_edge_only: assert property (wr_host && wr_data[BIT_COMM_ERROR_CLEAR] && state_reg.host_ctrl[BIT_COMM_ERROR_CLEAR] |=> !comm_error_clear_pulse)
    else $error("clear fired without a rising edge");
  a_clear_resets_cnt: assert property (comm_error_clear_pulse && !$past(bad_imm || comm_error_event) |->
    comm_error_count == '0)
    else $error("error clear left the counter set");
  a_lamp_bits: assert property (wr_host |=> alarm_lamp_suppress == $past(wr_data[15]) && excite_on == $past(wr_data[1]))
    else $error("lamp or excitation bit did not follow the write");
  // Error flag and counter, clear pulses, host control bits, rate writes, deferred words, commit and reads.
  a_clear_drops_flag: assert property (comm_error_clear_pulse && !$past(bad_imm || comm_error_event) |->
    !comm_error_flag)
    else $error("error clear left the flag set");
  a_clear_on_edge: assert property (wr_host && wr_data[BIT_COMM_ERROR_CLEAR] &&
    !state_reg.host_ctrl[BIT_COMM_ERROR_CLEAR] |=> comm_error_clear_pulse)
    else $error("rising clear bit gave no pulse");
  a_alarm_on_edge: assert property (wr_host && wr_data[BIT_ALARM_CLEAR_REQUEST] &&
    !state_reg.host_ctrl[BIT_ALARM_CLEAR_REQUEST] |=> alarm_clear_pulse)
    else $error("rising alarm reset bit gave no pulse");
  a_power_lamp_bit: assert property (wr_host |=>
    power_lamp_suppress == $past(wr_data[BIT_POWER_LAMP_SUPPRESS]))
    else $error("power lamp bit did not follow the write");
  a_filter_smooth_bits: assert property (wr_host |=>
    command_filter_on == $past(wr_data[BIT_COMMAND_FILTER_ON]) &&
    smooth_drive_on == $past(wr_data[BIT_SMOOTH_DRIVE_ON]))
    else $error("filter or smooth drive bit did not follow the write");
  a_host_rsvd_zero: assert property ((state_reg.host_ctrl & ~HOST_CTRL_MASK) == 16'h0000)
    else $error("reserved host control bits hold ones");
  a_alarm_clears_err: assert property (alarm_clear_pulse && !$past(commit_settings_command) |->
    !cmd_disable_error)
    else $error("alarm reset left the command error set");
  a_bad_imm_counts: assert property (bad_imm && comm_error_count != '1 |=>
    comm_error_count == $past(comm_error_count) + 1'b1)
    else $error("bad immediate write was not counted");
  a_good_hold_applies: assert property (wr_hold && !bad_imm |=> holding_current_rate == $past(wr_data))
    else $error("good holding rate write did not apply");
  a_defer_op_ignored: assert property (wr_en && !setting_state |=> $stable(state_reg.cfg_pend) &&
    $stable(state_reg.res_pend) && $stable(state_reg.frame_pend))
    else $error("deferred word changed during operation");
  a_cfg_frozen_op: assert property (!setting_state && !$past(setting_state) |->
    $stable(active_driver_config) && $stable(active_frame_size))
    else $error("active driver word or frame changed during operation");
  a_no_return: assert property (!setting_state |=> !setting_state)
    else $error("state went back from operation to setting");
  a_commit_ok_applies: assert property (commit_settings_command && setting_state && cif.ok |=>
    !setting_state && active_driver_config == $past(state_reg.cfg_pend) &&
    active_step_resolution == $past(state_reg.res_pend) && active_frame_size == $past(state_reg.frame_pend))
    else $error("good commit did not apply the pending words");
  a_commit_bad_reverts: assert property (commit_settings_command && setting_state && !cif.ok |=>
    $stable(active_step_resolution) && state_reg.res_pend == active_step_resolution)
    else $error("bad commit changed the active word or kept the pending one");
  a_rsvd_reads_zero: assert property (rd_en && (addr == ADDR_RSVD_A || addr == ADDR_RSVD_B) |=>
    rd_data == RSVD_READ_VALUE)
    else $error("reserved slot read returned data");
  a_read_run_rate: assert property (rd_en && addr == ADDR_RUN_RATE |=>
    rd_data == $past(running_current_rate))
    else $error("running rate read returned the wrong word");
  a_read_host_ctrl: assert property (rd_en && addr == ADDR_HOST_CTRL |=>
    rd_data == $past(state_reg.host_ctrl))
    else $error("host control read returned the wrong word");
  a_rd_idle_zero: assert property (!rd_en |=> rd_data == RSVD_READ_VALUE)
    else $error("read data stood without a read");
  // Full and half rate give the rated current and half of it, rounded down.
  a_full_rate_current: assert property (running_current_rate == RATE_SCALE |=>
    running_current_ma == $past(rated_current_ma))
    else $error("full running rate did not give the rated current");
  a_half_rate_current: assert property (running_current_rate == (RATE_SCALE >> 1) |=>
    running_current_ma == ($past(rated_current_ma) >> 1))
    else $error("half running rate did not give half the rated current");
  a_rated_base_frame: assert property (active_frame_size == FRAME_SEL_MAX |=>
    rated_current_ma == RATED_MA_BASE)
    else $error("top frame code did not give the base rated current");
  c_commit_ok: cover property (setting_state ##1 !setting_state);
  c_commit_bad: cover property ($rose(cmd_disable_error));
  c_err_clear: cover property (comm_error_flag ##1 comm_error_clear_pulse);
  c_bad_write: cover property (bad_imm);
  c_alarm_reset: cover property (cmd_disable_error ##1 alarm_clear_pulse);
endmodule
`default_nettype wire

// File: tb_stepper_function_setting_regs.sv
`default_nettype none
module tb_stepper_function_setting_regs
  import fsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, arst_n, wr_en, rd_en, commit_settings_command, comm_error_event;
  logic [3:0] addr;
  logic [15:0] wr_data, rd_data, running_current_rate, holding_current_rate, active_driver_config;
  logic [15:0] active_step_resolution, active_frame_size, rated_current_ma, running_current_ma, v;
  logic setting_state, alarm_lamp_suppress, power_lamp_suppress, command_filter_on, smooth_drive_on, excite_on;
  logic comm_error_flag, comm_error_clear_pulse, alarm_clear_pulse, cmd_disable_error, cmd_disable_alarm;
  logic [7:0] comm_error_count;
  logic [15:0] m_ctrl, m_cfg, m_res, m_frame, p_cfg, p_res, p_frame;
  logic [15:0] m_run = RUN_RATE_RESET;
  logic [15:0] m_hold = HOLD_RATE_RESET;
  logic [15:0] exp_q [$];
  int m_state = 1, m_flag = 0, m_cnt = 0, m_cmderr = 0, n_clr = 0, n_alm = 0, s_clr = 0, s_alm = 0;
  int bad_count = 0, n_tests = 0;
  wire logic [15:0] lamps = {alarm_lamp_suppress, power_lamp_suppress, 4'h0, command_filter_on, smooth_drive_on,
    6'h00, excite_on, 1'b0};
  wire logic [15:0] errs = {cmd_disable_error, cmd_disable_alarm, comm_error_flag, setting_state, 4'h0,
    comm_error_count};
  logic [19:0] plan [0:34] = '{20'h30000, 20'h30000, 20'h20000, 20'h20008, 20'h20008, 20'h30000, 20'h20008,
    20'h20000, 20'h20008, 20'h40000, 20'h40001, 20'h403E8, 20'h403E9, 20'h4FFFF, 20'h60000, 20'h60001, 20'h601F4,
    20'h601F5, 20'h50001, 20'h01234, 20'h8FFFF, 20'hA4000, 20'hC0003, 20'hEFA05, 20'h10000, 20'h20004, 20'hC0014,
    20'hEFE00, 20'h10000, 20'hC0008, 20'hA0000, 20'h10000, 20'h401F4, 20'h20306, 20'h60064};
  stepper_function_setting_regs #(.ERR_CNT_W(8)) i_dut (.sys_clk, .arst_n, .wr_en, .rd_en, .addr, .wr_data,
    .commit_settings_command, .comm_error_event, .rd_data, .setting_state, .alarm_lamp_suppress,
    .power_lamp_suppress, .command_filter_on, .smooth_drive_on, .excite_on, .comm_error_flag, .comm_error_count,
    .comm_error_clear_pulse, .alarm_clear_pulse, .cmd_disable_error, .cmd_disable_alarm, .running_current_rate,
    .holding_current_rate, .active_driver_config, .active_step_resolution, .active_frame_size, .rated_current_ma,
    .running_current_ma);
  fsr_host_model i_host (.sys_clk, .rd_data, .wr_en, .rd_en, .addr, .wr_data);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Pulses are counted rather than timed, so a one-cycle shift in the pulse does not hide a missing edge.
  always @(posedge sys_clk) begin
    if (comm_error_clear_pulse === 1'b1) s_clr++;
    if (alarm_clear_pulse === 1'b1) s_alm++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] exp_rd(input logic [3:0] a);
    case (a)
      ADDR_HOST_CTRL: return m_ctrl;
      ADDR_RUN_RATE: return m_run;
      ADDR_HOLD_RATE: return m_hold;
      ADDR_DRV_CFG: return p_cfg;
      ADDR_STEP_RES: return p_res;
      ADDR_FRAME_SEL: return p_frame;
      default: return RSVD_READ_VALUE;
    endcase
  endfunction
  function automatic bit ok_set();
    return p_frame >= 16'hFA05 && p_frame <= 16'hFF00 && (p_cfg & ~DRV_CFG_MASK) == 16'h0000 && p_cfg[14] &&
      p_res >= 16'h0004 && p_res <= 16'h09C4 && (p_res % 4 == 0 || p_res inside {10, 25, 50, 250});
  endfunction
  // Rated current follows the committed frame code: a fixed base plus one step per code below the top code.
  function automatic logic [15:0] exp_rated();
    return 16'(int'(RATED_MA_BASE) + (int'(FRAME_SEL_MAX) - int'(m_frame)) * int'(RATED_MA_STEP));
  endfunction
  task automatic chk_all();
    repeat (3) @(negedge sys_clk);
    check(lamps, m_ctrl & 16'hC302);
    check(errs, {m_cmderr[0], m_cmderr[0], m_flag[0], m_state[0], 4'h0, 8'(m_cnt)});
    check(16'(s_clr), 16'(n_clr));
    check(16'(s_alm), 16'(n_alm));
    check(running_current_rate, m_run);
    check(holding_current_rate, m_hold);
    check(active_driver_config, m_cfg);
    check(active_step_resolution, m_res);
    check(active_frame_size, m_frame);
    check(rated_current_ma, exp_rated());
    check(running_current_ma, 16'((32'(exp_rated()) * m_run) / 1000));
  endtask
  task automatic bump();
    m_cnt++;
    m_flag = 1;
  endtask
  task automatic step(input logic [19:0] e);
    logic [3:0] a;
    logic [15:0] d;
    a = e[19:16];
    d = e[15:0];
    if (a == 4'h1 || a == 4'h3) begin
      @(negedge sys_clk);
      commit_settings_command <= (a == 4'h1);
      comm_error_event <= (a == 4'h3);
      @(negedge sys_clk);
      commit_settings_command <= 1'b0;
      comm_error_event <= 1'b0;
      if (a == 4'h3) bump();
      else if (m_state == 1 && ok_set()) begin
        m_state = 0;
        {m_cfg, m_res, m_frame} = {p_cfg, p_res, p_frame};
      end else if (m_state == 1) begin
        m_cmderr = 1;
        {p_cfg, p_res, p_frame} = {m_cfg, m_res, m_frame};
      end
    end else begin
      i_host.write_word(a, d);
      case (a)
        ADDR_HOST_CTRL: begin
          if (d[3] && !m_ctrl[3]) begin
            n_clr++;
            m_cnt = 0;
            m_flag = 0;
          end
          if (d[2] && !m_ctrl[2]) begin
            n_alm++;
            m_cmderr = 0;
          end
          m_ctrl = d & HOST_CTRL_MASK;
        end
        ADDR_RUN_RATE: if (d >= 1 && d <= 1000) m_run = d; else bump();
        ADDR_HOLD_RATE: if (d >= 1 && d <= 500) m_hold = d; else bump();
        ADDR_DRV_CFG: if (m_state == 1) p_cfg = d;
        ADDR_STEP_RES: if (m_state == 1) p_res = d;
        ADDR_FRAME_SEL: if (m_state == 1) p_frame = d;
        default: ;
      endcase
    end
    chk_all();
    if (!a[0]) begin
      exp_q.push_back(exp_rd(a));
      i_host.read_word(a, v);
      check(v, exp_q.pop_front());
    end
  endtask
  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    bad_count++;
    conclude();
  end
  initial begin
    void'($urandom(32'hD2F7));
    arst_n = 1'b0;
    commit_settings_command = 1'b0;
    comm_error_event = 1'b0;
    m_ctrl = HOST_CTRL_RESET;
    {m_cfg, m_res, m_frame} = {DRV_CFG_RESET, STEP_RES_RESET, FRAME_SEL_RESET};
    {p_cfg, p_res, p_frame} = {m_cfg, m_res, m_frame};
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    chk_all();
    check(rated_current_ma, RATED_MA_BASE);
    for (int a = 0; a < 16; a += 2) step({4'(a), 16'h0000});
    repeat (12) step({ADDR_HOST_CTRL, 16'($urandom)});
    // Clear and alarm-reset bits are also written twice with no zero between, which gives no pulse, and deferred words precede commit.
    foreach (plan[i]) step(plan[i]);
    conclude();
  end
endmodule
`default_nettype wire
